// ===== core/ftsp_pkg.sv
// constants and types shared by the flow-through burst sram port
package ftsp_pkg;

	// ******************************************************************
	// organisations: lanes of nine bits and address depth
	// ******************************************************************
	localparam int LANE_W = 9;
	localparam int X36_LANES = 4;
	localparam int X36_ADDR_W = 21;
	localparam int X18_LANES = 2;
	localparam int X18_ADDR_W = 22;
	localparam int X72_LANES = 8;
	localparam int X72_ADDR_W = 20;

	typedef enum logic [1:0] {
		ORG_X36 = 2'h0,
		ORG_X18 = 2'h1,
		ORG_X72 = 2'h2
	} ftsp_org_e;

	// ******************************************************************
	// burst, access and buffer constants
	// ******************************************************************
	localparam int BURST_W = 2;
	localparam int RD_COPY_DEPTH = 32;
	localparam int CLK_MHZ = 100;
	localparam int MAX_BUS_MHZ = 133;

	typedef enum logic [1:0] {
		OP_IDLE = 2'h0,
		OP_READ = 2'h1,
		OP_WRITE = 2'h2
	} ftsp_op_e;

	function automatic int org_lanes(ftsp_org_e org);
		return (org == ORG_X18) ? X18_LANES : (org == ORG_X72) ? X72_LANES : X36_LANES;
	endfunction

	function automatic int org_addr_w(ftsp_org_e org);
		return (org == ORG_X18) ? X18_ADDR_W : (org == ORG_X72) ? X72_ADDR_W : X36_ADDR_W;
	endfunction

endpackage

// ===== core/ftsp_port.sv
// flow-through burst sram port with a read-copy fifo
//
// Notes on behaviour
// - every synchronous input is captured on the rising clock edge before use.
// - qualifier high ignores the edge; all access state holds unchanged.
// - write enable requests a write; only selected byte lanes change.
// - writes complete internally; no write pulse needed from the controller.
// - selected only when first and third selects low and second high.
// - output enable high tri-states data drivers at once, without the clock.
// - data drivers stay off during the data phase of every write.
// - back-to-back reads or writes run with no wait states.
// - read may follow write, and write follow read, on the next cycle.
// - read data comes straight from the array, no output register.
// - bursts run linear or interleaved, chosen by a static mode input.
// - sleep request or deselect puts the port into low power.
// - organisation is 2M x 36, 4M x 18 or 1M x 72.
`timescale 1ns/10ps

// ******************************************************************
// fifo with valid and ready on both sides
// ******************************************************************
module ftsp_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = ftsp_pkg::RD_COPY_DEPTH
) (
	input logic clk,
	input logic rst_n,
	input logic in_valid,
	output logic in_ready,
	input logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0] count;
	} ftsp_fifo_s;

	ftsp_fifo_s fifo_ff;
	ftsp_fifo_s nxt_fifo;
	logic [WIDTH-1:0] store_ff [DEPTH];
	logic push;
	logic pop;

	function automatic logic [PW-1:0] step_ptr(logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign in_ready = fifo_ff.count != (PW+1)'(DEPTH);
	assign out_valid = fifo_ff.count != '0;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = store_ff[fifo_ff.rd_ptr];

	always_comb begin
		nxt_fifo = fifo_ff;
		if (push) begin
			nxt_fifo.wr_ptr = step_ptr(fifo_ff.wr_ptr);
		end
		if (pop) begin
			nxt_fifo.rd_ptr = step_ptr(fifo_ff.rd_ptr);
		end
		if (push && !pop) begin
			nxt_fifo.count = (PW+1)'(fifo_ff.count + 1'b1);
		end else if (pop && !push) begin
			nxt_fifo.count = (PW+1)'(fifo_ff.count - 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_ff <= '0;
		end else begin
			fifo_ff <= nxt_fifo;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			store_ff[fifo_ff.wr_ptr] <= in_data;
		end
	end
endmodule

// ******************************************************************
// sram port
// ******************************************************************
module ftsp_port #(
	parameter ftsp_pkg::ftsp_org_e ORG = ftsp_pkg::ORG_X36,
	parameter int LANES = ftsp_pkg::org_lanes(ORG),
	parameter int ADDR_W = ftsp_pkg::org_addr_w(ORG),
	parameter int COPY_DEPTH = ftsp_pkg::RD_COPY_DEPTH
) (
	input logic ref_clk,
	input logic resetn,
	input logic clock_qualifier_n,
	input logic chip_select_first_n,
	input logic chip_select_second,
	input logic chip_select_third_n,
	input logic advance_or_load,
	input logic write_enable_n,
	input logic [LANES-1:0] byte_lane_write_select_n,
	input logic [ADDR_W-1:0] address,
	input logic burst_interleaved,
	input logic output_enable_n,
	input logic sleep_request,
	input logic [LANES*ftsp_pkg::LANE_W-1:0] dq_in,
	output logic [LANES*ftsp_pkg::LANE_W-1:0] dq_out,
	output logic dq_oe,
	output logic low_power,
	output logic rd_copy_space,
	output logic rd_copy_valid,
	input logic rd_copy_ready,
	output logic [LANES*ftsp_pkg::LANE_W-1:0] rd_copy_data
);
	localparam int LW = ftsp_pkg::LANE_W;
	localparam int W = LANES * LW;
	localparam int BW = ftsp_pkg::BURST_W;
	localparam int WORDS = 1 << ADDR_W;

	typedef struct packed {
		logic slp_meta;
		logic slp_sync;
		ftsp_pkg::ftsp_op_e op;
		logic [ADDR_W-1:0] base;
		logic [BW-1:0] cnt;
		logic [LANES-1:0] bw;
		logic commit;
		logic [ADDR_W-1:0] caddr;
		logic [LANES-1:0] cbw;
		logic [W-1:0] cdata;
	} ftsp_state_s;

	ftsp_state_s state_ff;
	ftsp_state_s nxt_state;
	logic [1:0] rst_n_ff;
	logic rst_n;
	logic [W-1:0] array_ff [WORDS];
	logic chip_active;
	logic rd_phase;
	logic [ADDR_W-1:0] cur_addr;
	logic [W-1:0] rd_word;
	logic copy_push;

	// ******************************************************************
	// helpers
	// ******************************************************************
	function automatic logic [BW-1:0] burst_low(logic [BW-1:0] start, logic [BW-1:0] cnt,
		logic ilv);
		return ilv ? (start ^ cnt) : BW'(start + cnt);
	endfunction

	function automatic logic [W-1:0] merge_lanes(logic [W-1:0] old_w, logic [W-1:0] new_w,
		logic [LANES-1:0] sel);
		logic [W-1:0] res;
		res = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (sel[i]) begin
				res[i*LW +: LW] = new_w[i*LW +: LW];
			end
		end
		return res;
	endfunction

	// ******************************************************************
	// reset release
	// ******************************************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_n_ff <= 2'h0;
		end else begin
			rst_n_ff <= {rst_n_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_n_ff[1];

	// ******************************************************************
	// access decode and flow-through read
	// ******************************************************************
	assign chip_active = !chip_select_first_n && chip_select_second && !chip_select_third_n;
	assign rd_phase = state_ff.op == ftsp_pkg::OP_READ;
	assign cur_addr = {state_ff.base[ADDR_W-1:BW],
		burst_low(state_ff.base[BW-1:0], state_ff.cnt, burst_interleaved)};

	// array output unregistered; a pending commit to the same word is merged in
	always_comb begin
		rd_word = array_ff[cur_addr];
		if (state_ff.commit && state_ff.caddr == cur_addr) begin
			rd_word = merge_lanes(rd_word, state_ff.cdata, state_ff.cbw);
		end
	end

	assign dq_out = rd_phase ? rd_word : '0;
	assign dq_oe = rd_phase && !output_enable_n;
	assign low_power = state_ff.slp_sync ||
		(state_ff.op == ftsp_pkg::OP_IDLE && !state_ff.commit);

	// ******************************************************************
	// next state
	// ******************************************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_state.slp_meta = sleep_request;
		nxt_state.slp_sync = state_ff.slp_meta;
		if (!clock_qualifier_n) begin
			nxt_state.commit = 1'b0;
			nxt_state.bw = ~byte_lane_write_select_n;
			unique case (state_ff.op)
				ftsp_pkg::OP_WRITE: begin
					nxt_state.commit = 1'b1;
					nxt_state.caddr = cur_addr;
					nxt_state.cbw = state_ff.bw;
					nxt_state.cdata = dq_in;
				end
				ftsp_pkg::OP_READ, ftsp_pkg::OP_IDLE: begin
				end
			endcase
			if (state_ff.slp_sync) begin
				nxt_state.op = ftsp_pkg::OP_IDLE;
			end else if (advance_or_load) begin
				nxt_state.cnt = BW'(state_ff.cnt + 1'b1);
			end else begin
				nxt_state.base = address;
				nxt_state.cnt = '0;
				if (!chip_active) begin
					nxt_state.op = ftsp_pkg::OP_IDLE;
				end else if (write_enable_n) begin
					nxt_state.op = ftsp_pkg::OP_READ;
				end else begin
					nxt_state.op = ftsp_pkg::OP_WRITE;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// self-timed array update from the captured write word
	always_ff @(posedge ref_clk) begin
		if (state_ff.commit && !clock_qualifier_n) begin
			array_ff[state_ff.caddr] <= merge_lanes(array_ff[state_ff.caddr], state_ff.cdata,
				state_ff.cbw);
		end
	end

	// ******************************************************************
	// read copy stream
	// ******************************************************************
	assign copy_push = rd_phase && !clock_qualifier_n;

	ftsp_fifo #(
		.WIDTH(W),
		.DEPTH(COPY_DEPTH)
	) u_copy (
		.clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(copy_push),
		.in_ready(rd_copy_space),
		.in_data(rd_word),
		.out_valid(rd_copy_valid),
		.out_ready(rd_copy_ready),
		.out_data(rd_copy_data)
	);

	// ******************************************************************
	// assertions
	// ******************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	logic load_read;
	logic load_write;
	assign load_read = !clock_qualifier_n && !advance_or_load && !state_ff.slp_sync &&
		chip_active && write_enable_n;
	assign load_write = !clock_qualifier_n && !advance_or_load && !state_ff.slp_sync &&
		chip_active && !write_enable_n;

	hold_on_stall_a: assert property (clock_qualifier_n |=>
		$stable(state_ff.op) && $stable(state_ff.cnt) && $stable(state_ff.commit))
		else $error("state moved while the clock qualifier was high");
	load_read_a: assert property (load_read |=> rd_phase && state_ff.cnt == '0)
		else $error("read load not taken");
	deselect_a: assert property (
		(!clock_qualifier_n && !advance_or_load && !chip_active) |=>
		state_ff.op == ftsp_pkg::OP_IDLE)
		else $error("deselect did not idle the port");
	write_tristate_a: assert property (
		state_ff.op == ftsp_pkg::OP_WRITE |-> !dq_oe)
		else $error("drivers on during write data phase");
	async_oe_a: assert property (output_enable_n |-> !dq_oe)
		else $error("drivers on with output enable inactive");
	commit_follow_a: assert property (
		(state_ff.op == ftsp_pkg::OP_WRITE && !clock_qualifier_n) |=>
		state_ff.commit && state_ff.cbw == $past(state_ff.bw) && state_ff.cdata == $past(dq_in))
		else $error("write word not captured");
	burst_adv_a: assert property (
		(!clock_qualifier_n && advance_or_load && !state_ff.slp_sync) |=>
		state_ff.cnt == $past(state_ff.cnt) + 2'h1)
		else $error("burst counter did not advance");
	sleep_power_a: assert property (
		sleep_request ##1 sleep_request |=> low_power)
		else $error("sleep did not reach low power");
	flow_read_a: assert property (
		(rd_phase && !output_enable_n) |-> dq_oe && dq_out == rd_word)
		else $error("read data not driven from array");
	wr_to_rd_a: assert property (
		(state_ff.op == ftsp_pkg::OP_WRITE && load_read) |=> rd_phase ##0 state_ff.commit)
		else $error("read after write was delayed");
	load_write_a: assert property (load_write |=>
		state_ff.op == ftsp_pkg::OP_WRITE && state_ff.bw == ~$past(byte_lane_write_select_n))
		else $error("write load not taken");
	addr_load_a: assert property (
		(!clock_qualifier_n && !advance_or_load && !state_ff.slp_sync) |=>
		state_ff.base == $past(address))
		else $error("load address not registered");
	adv_keep_a: assert property (
		(!clock_qualifier_n && advance_or_load && !state_ff.slp_sync) |=>
		$stable(state_ff.op) && $stable(state_ff.base))
		else $error("advance changed the loaded access");
	sleep_idle_a: assert property (
		(!clock_qualifier_n && state_ff.slp_sync) |=> state_ff.op == ftsp_pkg::OP_IDLE)
		else $error("access started during sleep");
	busy_power_a: assert property ((rd_phase && !state_ff.slp_sync) |-> !low_power)
		else $error("low power while reading");

	burst_read_c: cover property (load_read ##1 (advance_or_load && !clock_qualifier_n)[*3]);
	write_read_c: cover property (load_write ##1 load_read ##1 dq_oe);
	stall_c: cover property (rd_phase && clock_qualifier_n ##1 clock_qualifier_n);
	copy_full_c: cover property (!rd_copy_space);
	sleep_load_c: cover property (state_ff.slp_sync && !clock_qualifier_n && !advance_or_load);
endmodule

// ===== bench/ftsp_ctrl_model.sv
// memory controller model that drives the sram port bus
`timescale 1ns/10ps
module ftsp_ctrl_model #(
	parameter int LANES = 4,
	parameter int ADDR_W = 8
) (
	input logic ref_clk,
	input logic burst_interleaved,
	output logic clock_qualifier_n,
	output logic chip_select_first_n,
	output logic chip_select_second,
	output logic chip_select_third_n,
	output logic advance_or_load,
	output logic write_enable_n,
	output logic [LANES-1:0] byte_lane_write_select_n,
	output logic [ADDR_W-1:0] address,
	output logic [LANES*ftsp_pkg::LANE_W-1:0] dq_in
);
	localparam int LW = ftsp_pkg::LANE_W;
	localparam int W = LANES * LW;
	logic [W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [W-1:0] exp_q [$];
	logic [ADDR_W-1:0] start, cur;
	logic [LANES-1:0] wr_bw;
	logic [1:0] cnt, op;
	logic wr_pend, stall_en, quiet;
	initial begin
		{clock_qualifier_n, chip_select_first_n, chip_select_second, chip_select_third_n} = 4'h9;
		{advance_or_load, write_enable_n, byte_lane_write_select_n} = '1;
		address = '0;
		dq_in = '0;
		{wr_pend, stall_en, quiet, op, cnt} = '0;
	end
	// *****
	// one enabled edge; cs is first_n, second, third_n
	// *****
	task automatic beat(input logic wr, ld, input logic [ADDR_W-1:0] a,
		input logic [2:0] cs, input logic [LANES-1:0] bw);
		logic [W-1:0] d;
		d = W'({$urandom, $urandom});
		while (stall_en && $urandom_range(3) == 0) begin
			clock_qualifier_n <= 1'b1;
			address <= ADDR_W'($urandom);
			advance_or_load <= 1'($urandom);
			@(posedge ref_clk);
		end
		// data of the previous write beat goes out in this cycle
		for (int i = 0; i < LANES; i++) begin
			if (wr_pend && !wr_bw[i])
				mem[cur][i*LW +: LW] = d[i*LW +: LW];
		end
		if (ld) begin
			start = a;
			cnt = 2'h0;
			op = (cs != 3'b010) ? 2'h0 : (wr ? 2'h2 : 2'h1);
		end else begin
			cnt = cnt + 2'h1;
		end
		cur = {start[ADDR_W-1:2], burst_interleaved ? start[1:0] ^ cnt : start[1:0] + cnt};
		if (op == 2'h1 && !quiet) exp_q.push_back(mem[cur]);
		wr_pend = (op == 2'h2);
		wr_bw = bw;
		clock_qualifier_n <= 1'b0;
		{chip_select_first_n, chip_select_second, chip_select_third_n} <= cs;
		advance_or_load <= !ld;
		write_enable_n <= !wr;
		byte_lane_write_select_n <= bw;
		address <= ld ? a : ADDR_W'($urandom);
		dq_in <= d;
		@(posedge ref_clk);
	endtask
endmodule

// ===== bench/test_ftsp_port.sv
// self-checking bench for the flow-through sram port
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin errors++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module test_ftsp_port;
	localparam int AW = 8;
	localparam int W = 4 * ftsp_pkg::LANE_W;
	logic ref_clk = 1'b0, resetn = 1'b0, bi = 1'b0, oe_n = 1'b0, sleep = 1'b0;
	logic rdy = 1'b1, rnd_rdy = 1'b0;
	logic cq_n, cs1_n, cs2, cs3_n, adv, we_n, dq_oe, low_power, space, cvalid;
	logic [3:0] bw_n;
	logic [AW-1:0] addr;
	logic [W-1:0] dq_in, dq_out, cdata, e, c_exp;
	logic [W-1:0] copy_q [$];
	logic [2:0] pat [3] = '{3'b110, 3'b000, 3'b011};
	int errors = 0, check_count = 0;
	ftsp_ctrl_model #(.LANES(4), .ADDR_W(AW)) ftsp_ctrl_model_i (.ref_clk(ref_clk),
		.burst_interleaved(bi), .clock_qualifier_n(cq_n), .chip_select_first_n(cs1_n),
		.chip_select_second(cs2), .chip_select_third_n(cs3_n), .advance_or_load(adv),
		.write_enable_n(we_n), .byte_lane_write_select_n(bw_n), .address(addr), .dq_in(dq_in));
	ftsp_port #(.ADDR_W(AW)) ftsp_port_i (.ref_clk(ref_clk), .resetn(resetn),
		.clock_qualifier_n(cq_n), .chip_select_first_n(cs1_n), .chip_select_second(cs2),
		.chip_select_third_n(cs3_n), .advance_or_load(adv), .write_enable_n(we_n),
		.byte_lane_write_select_n(bw_n), .address(addr), .burst_interleaved(bi),
		.output_enable_n(oe_n), .sleep_request(sleep), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .low_power(low_power), .rd_copy_space(space), .rd_copy_valid(cvalid),
		.rd_copy_ready(rdy), .rd_copy_data(cdata));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// *****
	// monitor: each read beat takes the oldest note
	// *****
	always @(negedge ref_clk) begin
		if (resetn && cq_n === 1'b0 && dq_oe === 1'b1) begin
			e = ftsp_ctrl_model_i.exp_q.size() ? ftsp_ctrl_model_i.exp_q.pop_front() : 'x;
			`CHK("dq_out", e, dq_out)
			if (space === 1'b1) copy_q.push_back(e);
		end
		if (cvalid === 1'b1 && rdy === 1'b1) begin
			c_exp = copy_q.size() ? copy_q.pop_front() : 'x;
			`CHK("rd_copy_data", c_exp, cdata)
		end
	end
	always @(posedge ref_clk) begin
		if (rnd_rdy) rdy <= 1'($urandom);
	end
	task automatic beat(input logic wr, ld, input int a, input logic [2:0] cs,
		input logic [3:0] bw);
		ftsp_ctrl_model_i.beat(wr, ld, AW'(a), cs, bw);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#100us;
		errors++;
		$display("Error watchdog expected done seen timeout");
		report_and_stop();
	end
	// *****
	// tests
	// *****
	initial begin
		void'($urandom(32'h9574B381));
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 64; i++) beat(1'b1, i % 4 == 0, i, 3'b010, 4'h0);
		for (int i = 0; i < 64; i++) beat(1'b0, i % 4 == 0, i, 3'b010, 4'h0);
		$display("test fill_and_read done");
		rnd_rdy <= 1'b1;
		ftsp_ctrl_model_i.stall_en = 1'b1;
		for (int m = 0; m < 2; m++) begin
			// order select is static: idle the port before it changes
			beat(1'b0, 1'b1, 0, 3'b110, 4'h0);
			bi <= m[0];
			@(posedge ref_clk);
			for (int i = 0; i < 150; i++)
				beat(1'($urandom), i == 0 || $urandom_range(1) == 0, $urandom_range(63),
					3'b010, 4'($urandom));
			$display("test random_mix %0d done", m);
		end
		fork
			for (int i = 0; i < 8; i++) beat(1'b0, i % 4 == 0, 8 + i, 3'b010, 4'h0);
			begin
				for (int k = 0; k < 20; k++) begin
					@(negedge ref_clk);
					if (dq_oe === 1'b1) break;
				end
				`CHK("low_power", 1'b0, low_power)
				#2 oe_n = 1'b1;
				#1 `CHK("dq_oe", 1'b0, dq_oe)
				oe_n = 1'b0;
				#1 `CHK("dq_oe", 1'b1, dq_oe)
			end
		join
		$display("test output_enable done");
		for (int k = 0; k < 3; k++) begin
			beat(1'b0, 1'b1, k, pat[k], 4'h0);
			beat(1'b0, 1'b0, k, pat[k], 4'h0);
			@(negedge ref_clk);
			`CHK("low_power", 1'b1, low_power)
			@(posedge ref_clk);
		end
		sleep <= 1'b1;
		ftsp_ctrl_model_i.quiet = 1'b1;
		for (int i = 0; i < 8; i++) beat(1'b0, 1'b1, i, i < 4 ? 3'b110 : 3'b010, 4'h0);
		@(negedge ref_clk);
		`CHK("low_power", 1'b1, low_power)
		@(posedge ref_clk);
		sleep <= 1'b0;
		for (int i = 0; i < 4; i++) beat(1'b0, 1'b1, i, 3'b110, 4'h0);
		ftsp_ctrl_model_i.quiet = 1'b0;
		$display("test deselect_and_sleep done");
		rnd_rdy <= 1'b0;
		@(posedge ref_clk);
		rdy <= 1'b1;
		repeat (40) @(posedge ref_clk);
		rdy <= 1'b0;
		for (int i = 0; i < 40; i++) beat(1'b0, i % 4 == 0, i, 3'b010, 4'h0);
		beat(1'b0, 1'b1, 0, 3'b110, 4'h0);
		@(negedge ref_clk);
		`CHK("rd_copy_space", 1'b0, space)
		`CHK("copy_words", ftsp_pkg::RD_COPY_DEPTH, copy_q.size())
		@(posedge ref_clk);
		rnd_rdy <= 1'b1;
		repeat (200) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK("copy_words", 0, copy_q.size())
		`CHK("rd_copy_valid", 1'b0, cvalid)
		`CHK("pending_reads", 0, ftsp_ctrl_model_i.exp_q.size())
		$display("test copy_fill_drain done");
		report_and_stop();
	end
endmodule
